// File: core/async_serial_frame_tx.sv
// Operation
// - clock, transmit, receive enables at bits 7,6,5
// - all enables zero: stop, release both pins
// - exactly one start bit per frame
// - seven or eight character bits
// - one or two stop bits
// - even, odd, zero and no parity
// - length, parity, stops from mode register
// - control bit 1 picks bit order
// - control bit 0 inverts transmit pin
// - even parity transmit: one if odd ones
// - even parity receive: odd count is error
// - odd parity transmit: zero if odd ones
// - odd parity receive: even count is error
// - zero parity: send zero, never error
// - no parity: no bit, never error
// - clock enable first, then transmit enable
// - buffer write starts framed transmission
// - buffer copied to shift register, shifted out
// - completion pulse after final stop bit
// - idle until next buffer write
// - clock disabled: output high, input high, reset
// - enable cleared resets its own circuit
// - receiver checks only one stop bit
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "uart_frame_map.svh"

module async_serial_frame_tx (
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    input  wire logic [7:0]            addr_i,
    input  wire uart_frame_pkg::byte_t wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [7:0]                 rdata_o,
    input  wire logic                  serial_in_i,
    output logic                       serial_out_o,
    output logic                       tx_pin_en_o,
    output logic                       rx_pin_en_o,
    output logic                       tx_complete_irq_o,
    output logic                       rx_done_o,
    output logic                       rx_error_o
);
    import uart_frame_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] last_idx(input logic eight);
        last_idx = eight ? 3'h7 : 3'h6;
    endfunction

    // Tx shifter always emits bit 0 first, so MSB-first is a reversal
    function automatic byte_t order_bits(input byte_t d, input logic eight,
                                         input logic msb);
        byte_t r;
        r = 8'h00;
        if (!msb)
            r = eight ? d : {1'b0, d[6:0]};
        else if (eight)
            r = {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
        else
            r = {1'b0, d[0], d[1], d[2], d[3], d[4], d[5], d[6]};
        return r;
    endfunction

    function automatic logic [2:0] rx_pos(input logic [2:0] idx,
                                          input logic eight, input logic msb);
        rx_pos = msb ? 3'(last_idx(eight) - idx) : idx;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_s s_r;
    state_s s_nxt;

    logic   power;
    logic   tx_en;
    logic   rx_en;
    logic   eight;
    logic   msb;
    logic   two_stop;
    logic   [1:0] psel;
    logic   rx_line;
    logic   tx_tick;
    logic   rx_tick;
    logic   ones;

    assign power    = s_r.mode[`MODE_POWER];
    assign tx_en    = power & s_r.mode[`MODE_TXE];
    assign rx_en    = power & s_r.mode[`MODE_RXE];
    assign eight    = s_r.mode[`MODE_CL];
    assign two_stop = s_r.mode[`MODE_SL];
    assign psel     = {s_r.mode[`MODE_PSH], s_r.mode[`MODE_PSL]};
    assign msb      = s_r.ctrl[`CTRL_DIR];
    assign rx_line  = power ? s_r.sync2 : 1'b1;
    assign tx_tick  = (s_r.tx_tmr == 8'h00);
    assign rx_tick  = (s_r.rx_tmr == 8'h00);
    assign ones     = eight ? ^wdata_i : ^wdata_i[6:0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt         = s_r;
        s_nxt.tx_done = 1'b0;
        s_nxt.rx_done = 1'b0;
        s_nxt.rx_err  = 1'b0;
        s_nxt.rdata   = 8'h00;
        s_nxt.sync1   = serial_in_i;
        s_nxt.sync2   = s_r.sync1;
        s_nxt.rx_prev = rx_line;

        // Register writes
        if (wr_i) begin
            unique case (addr_i)
                `OFS_MODE: s_nxt.mode = wdata_i;
                `OFS_CTRL: s_nxt.ctrl = {6'h00, wdata_i[1:0]};
                `OFS_DIV:  s_nxt.div  = wdata_i;
                default: ;
            endcase
        end

        // Register reads; flag clears come first so a set later wins
        if (rd_i) begin
            unique case (addr_i)
                `OFS_MODE:   s_nxt.rdata = s_r.mode;
                `OFS_CTRL:   s_nxt.rdata = s_r.ctrl;
                `OFS_DIV:    s_nxt.rdata = s_r.div;
                `OFS_RXBUF: begin
                    s_nxt.rdata  = s_r.rx_buf;
                    s_nxt.rx_rdy = 1'b0;
                end
                `OFS_STATUS: begin
                    s_nxt.rdata = {3'h0, s_r.rx_rdy, s_r.ovr, s_r.ferr,
                                   s_r.perr, s_r.tx_st != TX_IDLE};
                    s_nxt.perr  = 1'b0;
                    s_nxt.ferr  = 1'b0;
                    s_nxt.ovr   = 1'b0;
                end
                default:     s_nxt.rdata = 8'h00;
            endcase
        end

        // --------------------------------------------------------
        // Transmitter
        // --------------------------------------------------------
        if (s_r.tx_st != TX_IDLE)
            s_nxt.tx_tmr = tx_tick ? s_r.div : 8'(s_r.tx_tmr - 8'h01);
        unique case (s_r.tx_st)
            TX_IDLE: begin
                // A write while busy is ignored; no second buffer stage
                if (wr_i && addr_i == `OFS_TXBUF && tx_en) begin
                    s_nxt.tx_shift = order_bits(wdata_i, eight, msb);
                    unique case (psel)
                        `PAR_EVEN: s_nxt.tx_par = ones;
                        `PAR_ODD:  s_nxt.tx_par = ~ones;
                        default:   s_nxt.tx_par = 1'b0;
                    endcase
                    s_nxt.tx_st    = TX_START;
                    s_nxt.tx_bit   = 1'b0;
                    s_nxt.tx_tmr   = s_r.div;
                    s_nxt.tx_idx   = 3'h0;
                    s_nxt.tx_stop2 = 1'b0;
                end
            end
            TX_START: begin
                if (tx_tick) begin
                    s_nxt.tx_st    = TX_DATA;
                    s_nxt.tx_bit   = s_r.tx_shift[0];
                    s_nxt.tx_shift = {1'b0, s_r.tx_shift[7:1]};
                end
            end
            TX_DATA: begin
                if (tx_tick) begin
                    if (s_r.tx_idx == last_idx(eight)) begin
                        if (psel == `PAR_NONE) begin
                            s_nxt.tx_st  = TX_STOP;
                            s_nxt.tx_bit = 1'b1;
                        end else begin
                            s_nxt.tx_st  = TX_PAR;
                            s_nxt.tx_bit = s_r.tx_par;
                        end
                    end else begin
                        s_nxt.tx_idx   = 3'(s_r.tx_idx + 3'h1);
                        s_nxt.tx_bit   = s_r.tx_shift[0];
                        s_nxt.tx_shift = {1'b0, s_r.tx_shift[7:1]};
                    end
                end
            end
            TX_PAR: begin
                if (tx_tick) begin
                    s_nxt.tx_st  = TX_STOP;
                    s_nxt.tx_bit = 1'b1;
                end
            end
            TX_STOP: begin
                if (tx_tick) begin
                    if (two_stop && !s_r.tx_stop2) begin
                        s_nxt.tx_stop2 = 1'b1;
                    end else begin
                        s_nxt.tx_st   = TX_IDLE;
                        s_nxt.tx_done = 1'b1;
                    end
                end
            end
            default: s_nxt.tx_st = TX_IDLE;
        endcase

        // --------------------------------------------------------
        // Receiver
        // --------------------------------------------------------
        if (s_r.rx_st != RX_IDLE)
            s_nxt.rx_tmr = rx_tick ? s_r.div : 8'(s_r.rx_tmr - 8'h01);
        unique case (s_r.rx_st)
            RX_IDLE: begin
                if (rx_en && s_r.rx_prev && !rx_line) begin
                    s_nxt.rx_st  = RX_START;
                    s_nxt.rx_tmr = {1'b0, s_r.div[7:1]};
                end
            end
            RX_START: begin
                // Re-check mid start bit to reject glitches
                if (rx_tick) begin
                    s_nxt.rx_st   = rx_line ? RX_IDLE : RX_DATA;
                    s_nxt.rx_idx  = 3'h0;
                    s_nxt.rx_data = 8'h00;
                    s_nxt.rx_par  = 1'b0;
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    s_nxt.rx_data[rx_pos(s_r.rx_idx, eight, msb)] = rx_line;
                    s_nxt.rx_par = s_r.rx_par ^ rx_line;
                    if (s_r.rx_idx == last_idx(eight))
                        s_nxt.rx_st = (psel == `PAR_NONE) ? RX_STOP : RX_PAR;
                    else
                        s_nxt.rx_idx = 3'(s_r.rx_idx + 3'h1);
                end
            end
            RX_PAR: begin
                if (rx_tick) begin
                    s_nxt.rx_par = s_r.rx_par ^ rx_line;
                    s_nxt.rx_st  = RX_STOP;
                end
            end
            RX_STOP: begin
                // Only the first stop bit is sampled
                if (rx_tick) begin
                    s_nxt.rx_st   = RX_IDLE;
                    s_nxt.rx_done = 1'b1;
                    if (!rx_line) begin
                        s_nxt.ferr   = 1'b1;
                        s_nxt.rx_err = 1'b1;
                    end
                    if ((psel == `PAR_EVEN && s_r.rx_par) ||
                        (psel == `PAR_ODD && !s_r.rx_par)) begin
                        s_nxt.perr   = 1'b1;
                        s_nxt.rx_err = 1'b1;
                    end
                    if (s_nxt.rx_rdy) begin
                        s_nxt.ovr    = 1'b1;
                        s_nxt.rx_err = 1'b1;
                    end else begin
                        s_nxt.rx_buf = s_r.rx_data;
                        s_nxt.rx_rdy = 1'b1;
                    end
                end
            end
            default: s_nxt.rx_st = RX_IDLE;
        endcase

        // --------------------------------------------------------
        // Enables
        // --------------------------------------------------------
        if (!tx_en) begin
            s_nxt.tx_st   = TX_IDLE;
            s_nxt.tx_bit  = 1'b1;
            s_nxt.tx_done = 1'b0;
        end
        if (!rx_en) begin
            s_nxt.rx_st   = RX_IDLE;
            s_nxt.rx_done = 1'b0;
            s_nxt.rx_err  = 1'b0;
        end
        if (!power) begin
            s_nxt.rx_rdy = 1'b0;
            s_nxt.perr   = 1'b0;
            s_nxt.ferr   = 1'b0;
            s_nxt.ovr    = 1'b0;
            s_nxt.rx_buf = 8'h00;
        end
        // Stopped channel drives high regardless of inversion
        s_nxt.tx_line = power ? (s_nxt.tx_bit ^ s_nxt.ctrl[`CTRL_INV])
                              : 1'b1;
        s_nxt.tx_pin_en = s_nxt.mode[`MODE_POWER]
                        & s_nxt.mode[`MODE_TXE];
        s_nxt.rx_pin_en = s_nxt.mode[`MODE_POWER]
                        & s_nxt.mode[`MODE_RXE];
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r         <= '0;
            s_r.mode    <= `MODE_RST;
            s_r.ctrl    <= `CTRL_RST;
            s_r.div     <= `DIV_RST;
            s_r.sync1   <= 1'b1;
            s_r.sync2   <= 1'b1;
            s_r.rx_prev <= 1'b1;
            s_r.tx_st   <= TX_IDLE;
            s_r.rx_st   <= RX_IDLE;
            s_r.tx_bit  <= 1'b1;
            s_r.tx_line <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o           = s_r.rdata;
    assign serial_out_o      = s_r.tx_line;
    assign tx_pin_en_o       = s_r.tx_pin_en;
    assign rx_pin_en_o       = s_r.rx_pin_en;
    assign tx_complete_irq_o = s_r.tx_done;
    assign rx_done_o         = s_r.rx_done;
    assign rx_error_o        = s_r.rx_err;

endmodule

// File: core/uart_frame_map.svh
`ifndef UART_FRAME_MAP_SVH
`define UART_FRAME_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_MODE        8'h00
`define OFS_CTRL        8'h04
`define OFS_TXBUF       8'h08
`define OFS_RXBUF       8'h0C
`define OFS_STATUS      8'h10
`define OFS_DIV         8'h14

// ----------------------------------------------------------------
// Operation mode register fields
// ----------------------------------------------------------------
`define MODE_POWER      7
`define MODE_TXE        6
`define MODE_RXE        5
`define MODE_PSH        4
`define MODE_PSL        3
`define MODE_CL         2
`define MODE_SL         1

// ----------------------------------------------------------------
// Channel control and status fields
// ----------------------------------------------------------------
`define CTRL_DIR        1
`define CTRL_INV        0
`define ST_TXBUSY       0
`define ST_PERR         1
`define ST_FERR         2
`define ST_OVR          3
`define ST_RXRDY        4

// ----------------------------------------------------------------
// Parity select codes {high, low}
// ----------------------------------------------------------------
`define PAR_NONE        2'h0
`define PAR_ZERO        2'h1
`define PAR_ODD         2'h2
`define PAR_EVEN        2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MODE_RST        8'h01
`define CTRL_RST        8'h00
`define DIV_RST         8'h0F

`endif

// File: core/uart_frame_pkg.sv
package uart_frame_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_PAR,
        TX_STOP
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PAR,
        RX_STOP
    } rx_state_e;

    typedef struct packed {
        byte_t     mode;
        byte_t     ctrl;
        byte_t     div;
        byte_t     rdata;
        logic      sync1;
        logic      sync2;
        logic      rx_prev;
        tx_state_e tx_st;
        byte_t     tx_shift;
        logic      tx_par;
        logic      tx_bit;
        logic      tx_stop2;
        logic [2:0] tx_idx;
        byte_t     tx_tmr;
        logic      tx_line;
        logic      tx_done;
        rx_state_e rx_st;
        byte_t     rx_data;
        logic      rx_par;
        logic [2:0] rx_idx;
        byte_t     rx_tmr;
        byte_t     rx_buf;
        logic      rx_rdy;
        logic      perr;
        logic      ferr;
        logic      ovr;
        logic      rx_done;
        logic      rx_err;
        logic      tx_pin_en;
        logic      rx_pin_en;
    } state_s;

endpackage

// File: test/async_serial_frame_chk.sv
`timescale 1ns/1ps
module async_serial_frame_chk (
    input wire logic                  clk_i,
    input wire logic                  rstn_i,
    input wire logic [7:0]            addr_i,
    input wire uart_frame_pkg::byte_t wdata_i,
    input wire logic                  wr_i,
    input wire logic                  rd_i,
    input wire logic [7:0]            rdata_o,
    input wire logic                  serial_in_i,
    input wire logic                  serial_out_o,
    input wire logic                  tx_pin_en_o,
    input wire logic                  rx_pin_en_o,
    input wire logic                  tx_complete_irq_o,
    input wire logic                  rx_done_o,
    input wire logic                  rx_error_o
);
    import uart_frame_pkg::*;
    // ------------------------------------------------
    // Shadow of mode and control writes
    // ------------------------------------------------
    logic [7:0] mode_r;
    logic [7:0] ctrl_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_r <= 8'h01;
            ctrl_r <= 8'h00;
        end else if (wr_i && addr_i == 8'h00) begin
            mode_r <= wdata_i;
        end else if (wr_i && addr_i == 8'h04) begin
            ctrl_r <= wdata_i;
        end
    end
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    AST_RDATA_UNMAPPED: assert property (
        rd_i && addr_i == 8'h20 |=> rdata_o == 8'h00)
        else $error("unmapped read returned data");
    AST_PIN_EN: assert property (!$past(wr_i) |->
        tx_pin_en_o == (mode_r[7] && mode_r[6]) &&
        rx_pin_en_o == (mode_r[7] && mode_r[5]))
        else $error("pin enables do not follow mode");
    AST_POWER_OFF: assert property (!$past(wr_i) && !mode_r[7] |->
        serial_out_o && !tx_pin_en_o && !rx_pin_en_o)
        else $error("stopped channel holds pins");
    AST_IRQ_PULSE: assert property (tx_complete_irq_o |=> !tx_complete_irq_o)
        else $error("completion pulse longer than one cycle");
    AST_IRQ_NEEDS_TX: assert property (
        tx_complete_irq_o |-> mode_r[7] && mode_r[6])
        else $error("completion with transmitter disabled");
    AST_IRQ_LINE_IDLE: assert property (
        tx_complete_irq_o |-> serial_out_o == !ctrl_r[0])
        else $error("line not at stop level at completion");
    AST_QUIET_AFTER_IRQ: assert property (
        tx_complete_irq_o && !wr_i ##1 !wr_i [*3] |->
        $stable(serial_out_o) && !tx_complete_irq_o)
        else $error("transmitter active without buffer write");
    AST_RXDONE_PULSE: assert property (rx_done_o |=> !rx_done_o)
        else $error("receive done longer than one cycle");
    AST_RXERR_WITH_DONE: assert property (rx_error_o |-> rx_done_o)
        else $error("receive error without done");
endmodule

bind async_serial_frame_tx async_serial_frame_chk u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o), .tx_pin_en_o(tx_pin_en_o),
    .rx_pin_en_o(rx_pin_en_o), .tx_complete_irq_o(tx_complete_irq_o),
    .rx_done_o(rx_done_o), .rx_error_o(rx_error_o));

// File: test/serial_far_end.sv
`timescale 1ns/1ps
module serial_far_end #(
    parameter int BIT_CYC = 8
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    // Line idles high between frames
    initial line_o = 1'b1;
    // ------------------------------------------------
    // Capture n bit levels, start bit included
    // ------------------------------------------------
    // Sampled at the falling edge, away from the launching edge
    task automatic recv(input logic inv, input int n,
                        output logic [15:0] bits, output bit ok);
        int t;
        bits = '0;
        ok = 1'b0;
        for (t = 0; t < 4000 && line_i !== inv; t++) @(negedge clk_i);
        if (line_i !== inv) return;
        repeat (BIT_CYC / 2) @(negedge clk_i);
        // No wait after the last stop sample, so the completion pulse
        // that follows it is still ahead of the caller
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (BIT_CYC) @(negedge clk_i);
            bits[i] = line_i;
        end
        ok = 1'b1;
    endtask
    // ------------------------------------------------
    // Send n prepared bits, then return to idle
    // ------------------------------------------------
    task automatic send(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            line_o <= bits[i];
            repeat (BIT_CYC - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
    import uart_frame_pkg::*;
    localparam int DIVV = 7;
    localparam int BIT = DIVV + 1;
    logic       clk_i, rstn_i, wr_i, rd_i, serial_in_i, serial_out_o;
    logic       tx_pin_en_o, rx_pin_en_o, tx_complete_irq_o;
    logic       rx_done_o, rx_error_o;
    logic [7:0] addr_i, rdata_o;
    byte_t      wdata_i;
    int         n_fail, n_checks;

    async_serial_frame_tx u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
        .tx_pin_en_o(tx_pin_en_o), .rx_pin_en_o(rx_pin_en_o),
        .tx_complete_irq_o(tx_complete_irq_o), .rx_done_o(rx_done_o),
        .rx_error_o(rx_error_o));
    serial_far_end #(.BIT_CYC(BIT)) u_far (
        .clk_i(clk_i), .line_i(serial_out_o), .line_o(serial_in_i));
    // ------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic timed_out(input string what);
        n_fail++;
        $display("Error %s expected event seen timeout", what);
        results();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // Expected frame levels before inversion; returns bit count
    function automatic int frame(input logic [7:0] m, c, d,
                                 output logic [15:0] f);
        int len;
        logic p;
        len = m[2] ? 8 : 7;
        f = '0;
        for (int i = 0; i < len; i++) f[1 + i] = c[1] ? d[len-1-i] : d[i];
        p = ^(d & (m[2] ? 8'hFF : 8'h7F));
        case (m[4:3])
            2'b11: f[len + 1] = p;
            2'b10: f[len + 1] = ~p;
            default: f[len + 1] = 1'b0;
        endcase
        len = len + ((m[4:3] != 2'b00) ? 2 : 1);
        f[len] = 1'b1;
        f[len + 1] = m[1];
        return len + (m[1] ? 2 : 1);
    endfunction
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs;
        logic [7:0] r;
        rd(8'h00, r); check("mode reset", 16'h01, 16'(r));
        rd(8'h04, r); check("ctrl reset", 16'h00, 16'(r));
        rd(8'h20, r); check("unmapped read", 16'h00, 16'(r));
        wr(8'h14, 8'(DIVV));
        rd(8'h14, r); check("divider", 16'(DIVV), 16'(r));
    endtask
    task automatic t_tx(input logic [7:0] m, c, d);
        logic [15:0] e, g, k;
        bit ok;
        int n, t;
        n = frame(m, c, d, e);
        k = (16'h1 << n) - 16'h1;
        e = (e ^ {16{c[0]}}) & k;
        wr(8'h04, c);
        wr(8'h00, m & 8'h9F);
        wr(8'h00, m);
        repeat (2) @(negedge clk_i);
        check("tx pin enable", 16'h1, 16'(tx_pin_en_o));
        fork
            u_far.recv(c[0], n, g, ok);
            wr(8'h08, d);
        join
        if (!ok) timed_out("start bit");
        check("tx frame", e, g & k);
        for (t = 0; t < 2 * BIT && tx_complete_irq_o !== 1'b1; t++) @(negedge clk_i);
        if (tx_complete_irq_o !== 1'b1) timed_out("tx complete");
        repeat (4 * BIT) @(negedge clk_i);
        check("idle line", 16'(!c[0]), 16'(serial_out_o));
    endtask
    task automatic t_rx(input logic [7:0] m, c, d, input logic flip, ee);
        logic [15:0] f;
        logic [7:0]  r;
        logic        dn, er;
        int          n, t;
        n = frame(m & 8'hFD, c, d, f);
        if (flip) f[n - 2] = ~f[n - 2];
        wr(8'h04, c);
        wr(8'h00, m);
        dn = 1'b0;
        er = 1'b0;
        fork
            u_far.send(f, n);
            begin
                for (t = 0; t < 16 * BIT && !dn; t++) begin
                    @(negedge clk_i);
                    dn = (rx_done_o === 1'b1);
                    er = rx_error_o;
                end
            end
        join
        if (!dn) timed_out("rx done");
        check("rx error", 16'(ee), 16'(er));
        rd(8'h0C, r);
        check("rx data", 16'(d & (m[2] ? 8'hFF : 8'h7F)), 16'(r));
        rd(8'h10, r);
    endtask
    task automatic t_stop;
        logic seen;
        wr(8'h04, 8'h01);
        wr(8'h00, 8'hC4);
        wr(8'h08, 8'h00);
        repeat (3 * BIT) @(negedge clk_i);
        wr(8'h00, 8'h84);
        seen = 1'b0;
        repeat (16 * BIT) begin
            @(negedge clk_i);
            seen = seen | (tx_complete_irq_o !== 1'b0);
        end
        check("abort completion", 16'h0, 16'(seen));
        check("abort line", 16'h0, 16'(serial_out_o));
        wr(8'h00, 8'h00);
        repeat (2) @(negedge clk_i);
        check("stopped line", 16'h1, 16'(serial_out_o));
        check("stopped pins", 16'h0, 16'({tx_pin_en_o, rx_pin_en_o}));
        wr(8'h00, 8'h40);
        wr(8'h08, 8'h00);
        repeat (4 * BIT) begin
            @(negedge clk_i);
            seen = seen | (serial_out_o !== 1'b1);
        end
        check("no clock no frame", 16'h0, 16'(seen));
    endtask
    // ------------------------------------------------
    // Clock, reset and sequence
    // ------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        {rstn_i, wr_i, rd_i} = 3'b000;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        n_fail = 0;
        n_checks = 0;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_regs();
        t_tx(8'hFC, 8'h00, 8'h55);
        t_tx(8'hFC, 8'h03, 8'h55);
        t_tx(8'hF2, 8'h00, 8'h36);
        t_tx(8'hE4, 8'h00, 8'h87);
        t_tx(8'hEE, 8'h02, 8'hFF);
        t_rx(8'hFE, 8'h00, 8'hA5, 1'b0, 1'b0);
        t_rx(8'hFE, 8'h00, 8'hA5, 1'b1, 1'b1);
        t_rx(8'hF0, 8'h02, 8'h4B, 1'b1, 1'b1);
        t_rx(8'hF0, 8'h02, 8'h4B, 1'b0, 1'b0);
        t_rx(8'hEC, 8'h00, 8'h5A, 1'b1, 1'b0);
        t_rx(8'hE4, 8'h00, 8'h3C, 1'b0, 1'b0);
        t_stop();
        results();
    end
endmodule
